// >>> verilog/trig_chan_pkg.sv
/*
 trig_chan_pkg: command codes, field widths, channel limits and fault bit positions
 for the trigger arming and channel selection interpreter.
 assumes: a parser upstream decodes text commands into the codes below.
*/
package trig_chan_pkg;
   // ==========================================
   // command codes
   typedef enum logic [3:0]
   {
      cmd_none = 4'h0,
      cmd_single_arm = 4'h1,
      cmd_continuous_arm = 4'h2,
      cmd_continuous_query = 4'h3,
      cmd_general_reset = 4'h4,
      cmd_channel_list_query = 4'h5,
      cmd_channel_select = 4'h6,
      cmd_numbered_select = 4'h7,
      cmd_selected_query = 4'h8,
      cmd_output_gate = 4'h9,
      cmd_measured_current_query = 4'ha,
      cmd_measured_voltage_query = 4'hb,
      cmd_trigger = 4'hc
   } cmd_t;

   // ==========================================
   // widths and limits
   localparam int chan_w = 5;
   localparam int chan_count = 32;
   localparam int level_w = 16;
   localparam int meas_w = 16;
   localparam int ques_w = 16;
   localparam logic [chan_w-1:0] chan_min = 5'h01;
   localparam logic [chan_w-1:0] chan_max = 5'h1f;
   localparam logic [chan_w-1:0] chan_reset_value = 5'h01;
   // questionable register bit positions
   localparam int ques_power_loss_bit = 11;
   localparam int ques_cmd_warning_bit = 13;
   // reset pulse to a supply lasts this many ns, rounded up to whole cycles, before it goes on-line
   localparam int supply_reset_ns = 100;
   localparam int clk_period_ns = 5;
   localparam int supply_reset_cycles = (supply_reset_ns + clk_period_ns - 1) / clk_period_ns;
   localparam int rst_cnt_w = 5;

   // ==========================================
   // answer kinds
   typedef enum logic [2:0]
   {
      ans_none = 3'h0,
      ans_flag = 3'h1,
      ans_list = 3'h2,
      ans_channel = 3'h3,
      ans_current = 3'h4,
      ans_voltage = 3'h5
   } ans_t;
endpackage

// >>> verilog/arm_keeper.sv
/*
 arm_keeper: holds the continuous arming flag and the single-shot arm state,
 consumes the single-shot arm on each trigger; a continuous arm is not consumed.
 assumes: command strobes are one-cycle pulses on clk.
*/
`timescale 1ns/100ps
module arm_keeper
(
   input wire logic clk,
   input wire logic rst,
   input wire logic set_continuous,
   input wire logic clear_continuous,
   input wire logic single_arm,
   input wire logic trigger,
   output logic continuous,
   output logic armed,
   output logic fire
);
   logic single_armed;
   logic next_single_armed;
   logic next_continuous;
   logic next_armed;

   // ==========================================
   // arming decode
   // clear beats set when both strobes arrive in the same cycle
   assign next_continuous = clear_continuous ? 1'b0 : (set_continuous ? 1'b1 : continuous);
   // a trigger consumes the single arm; a new arm in the same cycle re-arms
   assign next_single_armed = (single_arm && !continuous) ? 1'b1 :
                              (trigger ? 1'b0 : single_armed);
   // registered so the armed output comes straight from a flop
   assign next_armed = next_continuous || next_single_armed;

   // ==========================================
   // state
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         continuous <= 1'b0;
         single_armed <= 1'b0;
         fire <= 1'b0;
         armed <= 1'b0;
      end
      else
      begin
         continuous <= next_continuous;
         single_armed <= next_single_armed;
         armed <= next_armed;
         fire <= trigger && armed;
      end
   end
endmodule

// >>> verilog/trigger_arm_channel_select.sv
/*
 trigger_arm_channel_select: interpreter for arming, channel select, output gating
 and measurement queries of a multi-channel power module controller.
 assumes: cmd_valid is a one-cycle pulse with cmd, cmd_arg and cmd_extra decoded
 by an upstream parser; fieldbus presence and fault inputs come from pins.
*/
// What this block does
// - continuous flag set by 1, cleared by 0
// - immediate arm arms exactly one trigger
// - continuous set keeps armed; arm redundant
// - general reset clears continuous flag
// - continuous query answers one or zero
// - list query returns known channel set
// - list query never rescans; reset rescans
// - select 1..31 steers later commands
// - select returns offline supply online
// - supply reset before going back online
// - numbered select same as channel select
// - selected query returns current channel
// - gate zero drives zero; one restores levels
// - current query returns measured terminal current
// - voltage query returns measured terminal voltage
// - extra current or voltage query characters set warning bit 13
// - power-loss bit 11 makes supply unselectable
// - consumed trigger needs re-arming first
`timescale 1ns/100ps
module trigger_arm_channel_select
(
   input wire logic clk,
   input wire logic rst,
   input wire logic cmd_valid,
   input wire trig_chan_pkg::cmd_t cmd,
   input wire logic [4:0] cmd_arg,
   input wire logic cmd_extra,
   input wire logic [31:0] bus_present,
   input wire logic [31:0] bus_power_loss,
   input wire logic [15:0] prog_voltage,
   input wire logic [15:0] prog_current,
   input wire logic [15:0] meas_voltage,
   input wire logic [15:0] meas_current,
   output logic ans_valid,
   output trig_chan_pkg::ans_t ans_kind,
   output logic [31:0] ans_data,
   output logic [4:0] selected_channel,
   output logic [31:0] known_channels,
   output logic [31:0] supply_reset,
   output logic [15:0] out_voltage,
   output logic [15:0] out_current,
   output logic output_gated_off,
   output logic trigger_armed,
   output logic trigger_fire,
   output logic continuous_arm_flag,
   output logic [15:0] questionable,
   output logic cmd_error
);
   // ==========================================
   // pin synchronisers: three stages, accept when last two agree
   logic [31:0] present_s1;
   logic [31:0] present_s2;
   logic [31:0] present_s3;
   logic [31:0] present_q;
   logic [31:0] loss_s1;
   logic [31:0] loss_s2;
   logic [31:0] loss_s3;
   logic [31:0] loss_q;
   logic [31:0] next_present_q;
   logic [31:0] next_loss_q;

   assign next_present_q = (present_s2 & present_s3) | (present_q & (present_s2 | present_s3));
   assign next_loss_q = (loss_s2 & loss_s3) | (loss_q & (loss_s2 | loss_s3));

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         present_s1 <= 32'h0;
         present_s2 <= 32'h0;
         present_s3 <= 32'h0;
         present_q <= 32'h0;
      end
      else
      begin
         present_s1 <= bus_present;
         present_s2 <= present_s1;
         present_s3 <= present_s2;
         present_q <= next_present_q;
      end
   end

   // power-loss lines take the same filter, so a glitch cannot drop a channel
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         loss_s1 <= 32'h0;
         loss_s2 <= 32'h0;
         loss_s3 <= 32'h0;
         loss_q <= 32'h0;
      end
      else
      begin
         loss_s1 <= bus_power_loss;
         loss_s2 <= loss_s1;
         loss_s3 <= loss_s2;
         loss_q <= next_loss_q;
      end
   end

   // ==========================================
   // command decode
   logic is_single_arm;
   logic is_cont_arm;
   logic is_cont_query;
   logic is_reset;
   logic is_list_query;
   logic is_select;
   logic is_sel_query;
   logic is_gate;
   logic is_curr_query;
   logic is_volt_query;
   logic is_trigger;
   logic arg_in_range;
   logic target_lost;
   logic select_ok;
   logic select_bad;
   logic recover_busy;
   logic set_cont;
   logic clear_cont;

   assign is_single_arm = cmd_valid && (cmd == trig_chan_pkg::cmd_single_arm);
   assign is_cont_arm = cmd_valid && (cmd == trig_chan_pkg::cmd_continuous_arm);
   assign is_cont_query = cmd_valid && (cmd == trig_chan_pkg::cmd_continuous_query);
   assign is_reset = cmd_valid && (cmd == trig_chan_pkg::cmd_general_reset);
   assign is_list_query = cmd_valid && (cmd == trig_chan_pkg::cmd_channel_list_query);
   assign is_select = cmd_valid && ((cmd == trig_chan_pkg::cmd_channel_select) ||
                                    (cmd == trig_chan_pkg::cmd_numbered_select));
   assign is_sel_query = cmd_valid && (cmd == trig_chan_pkg::cmd_selected_query);
   assign is_gate = cmd_valid && (cmd == trig_chan_pkg::cmd_output_gate);
   assign is_curr_query = cmd_valid && (cmd == trig_chan_pkg::cmd_measured_current_query);
   assign is_volt_query = cmd_valid && (cmd == trig_chan_pkg::cmd_measured_voltage_query);
   assign is_trigger = cmd_valid && (cmd == trig_chan_pkg::cmd_trigger);
   assign arg_in_range = (cmd_arg >= trig_chan_pkg::chan_min) && (cmd_arg <= trig_chan_pkg::chan_max);
   assign target_lost = loss_q[cmd_arg];
   // a supply still reporting power loss cannot be selected
   assign select_ok = is_select && arg_in_range && !target_lost && !recover_busy;
   assign select_bad = is_select && !select_ok;
   // bit 0 of the argument carries on or off
   assign set_cont = is_cont_arm && cmd_arg[0];
   assign clear_cont = (is_cont_arm && !cmd_arg[0]) || is_reset;

   // ==========================================
   // arming
   arm_keeper u_arm
   (
      .clk(clk),
      .rst(rst),
      .set_continuous(set_cont),
      .clear_continuous(clear_cont),
      .single_arm(is_single_arm),
      .trigger(is_trigger),
      .continuous(continuous_arm_flag),
      .armed(trigger_armed),
      .fire(trigger_fire)
   );

   // ==========================================
   // channel selection and recovery
   typedef enum logic [1:0] {rec_idle, rec_reset, rec_online} rec_state_t;
   rec_state_t rec_state;
   rec_state_t next_rec_state;
   logic [4:0] rec_chan;
   logic [4:0] next_rec_chan;
   logic [4:0] rec_cnt;
   logic [4:0] next_rec_cnt;
   logic [4:0] next_selected;
   logic [31:0] next_supply_reset;
   logic [31:0] chan_onehot;
   logic [31:0] next_known;
   logic rec_done;

   assign recover_busy = (rec_state != rec_idle);
   assign chan_onehot = 32'h1 << rec_chan;
   assign rec_done = (rec_cnt == 5'(trig_chan_pkg::supply_reset_cycles - 1));
   assign next_rec_chan = select_ok ? cmd_arg : rec_chan;
   assign next_selected = select_ok ? cmd_arg : selected_channel;
   assign next_rec_cnt = (rec_state == rec_reset) ? rec_cnt + 5'h01 : 5'h00;
   // a fresh select names its channel a cycle before rec_chan holds it
   assign next_supply_reset = (next_rec_state == rec_reset) ? (32'h1 << next_rec_chan) : 32'h0;

   always_comb
   begin
      next_rec_state = rec_state;
      case (rec_state)
         rec_idle:
            if (select_ok)
               next_rec_state = rec_reset;
         rec_reset:
            if (rec_done)
               next_rec_state = rec_online;
         rec_online:
            next_rec_state = rec_idle;
         default:
            next_rec_state = rec_idle;
      endcase
   end

   // list only changes on a rescan, a recovery or loss; the query itself reads it
   assign next_known = is_reset ? (present_q & ~loss_q) :
                       (((rec_state == rec_online) ? (known_channels | chan_onehot) : known_channels)
                        & ~loss_q);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rec_state <= rec_idle;
         rec_chan <= trig_chan_pkg::chan_reset_value;
         rec_cnt <= 5'h00;
      end
      else
      begin
         rec_state <= next_rec_state;
         rec_chan <= next_rec_chan;
         rec_cnt <= next_rec_cnt;
      end
   end

   // supply held in reset before it rejoins the list
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         selected_channel <= trig_chan_pkg::chan_reset_value;
         known_channels <= 32'h0;
         supply_reset <= 32'h0;
      end
      else
      begin
         selected_channel <= next_selected;
         known_channels <= next_known;
         supply_reset <= next_supply_reset;
      end
   end

   // ==========================================
   // output gating
   logic gate_on;
   logic next_gate_on;
   logic [15:0] next_out_voltage;
   logic [15:0] next_out_current;

   assign next_out_voltage = gate_on ? prog_voltage : 16'h0000;
   assign next_out_current = gate_on ? prog_current : 16'h0000;
   // only the output is zeroed; prog levels stay upstream, so gate on restores them
   assign next_gate_on = is_gate ? cmd_arg[0] : gate_on;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         gate_on <= 1'b1;
      end
      else
      begin
         gate_on <= next_gate_on;
      end
   end

   // outputs lag the gate by one cycle
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         out_voltage <= 16'h0000;
         out_current <= 16'h0000;
         output_gated_off <= 1'b0;
      end
      else
      begin
         out_voltage <= next_out_voltage;
         out_current <= next_out_current;
         output_gated_off <= !gate_on;
      end
   end

   // ==========================================
   // answers and status
   logic next_ans_valid;
   trig_chan_pkg::ans_t next_ans_kind;
   logic [31:0] next_ans_data;
   logic [15:0] warn_mask;
   logic [15:0] loss_mask;
   logic [15:0] ques_kept;
   logic [15:0] ques_new;
   logic [15:0] next_questionable;

   assign next_ans_valid = is_cont_query || is_list_query || is_sel_query || is_curr_query || is_volt_query;
   assign next_ans_kind = is_cont_query ? trig_chan_pkg::ans_flag :
                          is_list_query ? trig_chan_pkg::ans_list :
                          is_sel_query ? trig_chan_pkg::ans_channel :
                          is_curr_query ? trig_chan_pkg::ans_current :
                          is_volt_query ? trig_chan_pkg::ans_voltage : trig_chan_pkg::ans_none;
   // list is a channel bitmap; the text formatter adds the commas and exponent form
   assign next_ans_data = is_cont_query ? {31'h0, continuous_arm_flag} :
                          is_list_query ? known_channels :
                          is_sel_query ? {27'h0, selected_channel} :
                          is_curr_query ? {16'h0, meas_current} :
                          is_volt_query ? {16'h0, meas_voltage} : 32'h0;
   assign warn_mask = 16'h1 << trig_chan_pkg::ques_cmd_warning_bit;
   assign loss_mask = (|(loss_q & (32'h1 << selected_channel))) ? (16'h1 << trig_chan_pkg::ques_power_loss_bit) : 16'h0;
   // bit 11 is rebuilt each cycle from the live loss of the selected channel
   assign ques_kept = is_reset ? 16'h0000 : (questionable & ~(16'h1 << trig_chan_pkg::ques_power_loss_bit));
   assign ques_new = ((is_curr_query || is_volt_query) && cmd_extra) ? warn_mask : 16'h0000;
   // warning is sticky until a general reset; a new warning wins over reset
   assign next_questionable = ques_kept | ques_new | loss_mask;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ans_valid <= 1'b0;
         ans_kind <= trig_chan_pkg::ans_none;
         ans_data <= 32'h0;
      end
      else
      begin
         ans_valid <= next_ans_valid;
         ans_kind <= next_ans_kind;
         ans_data <= next_ans_data;
      end
   end

   // answers stand one cycle only; the formatter must take them then
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         questionable <= 16'h0000;
         cmd_error <= 1'b0;
      end
      else
      begin
         questionable <= next_questionable;
         cmd_error <= select_bad;
      end
   end
endmodule

// >>> tb/trig_props.sv
/*
 trig_props: concurrent checks on the interpreter top ports.
 assumes: one clock, async active-high rst, bound to the top module.
*/
`timescale 1ns/100ps
module trig_props
(
   input wire logic clk,
   input wire logic rst,
   input wire logic cmd_valid,
   input wire trig_chan_pkg::cmd_t cmd,
   input wire logic [4:0] cmd_arg,
   input wire logic cmd_extra,
   input wire logic ans_valid,
   input wire trig_chan_pkg::ans_t ans_kind,
   input wire logic [31:0] ans_data,
   input wire logic [4:0] selected_channel,
   input wire logic [15:0] out_voltage,
   input wire logic [15:0] out_current,
   input wire logic output_gated_off,
   input wire logic trigger_armed,
   input wire logic trigger_fire,
   input wire logic continuous_arm_flag,
   input wire logic [15:0] questionable,
   input wire logic cmd_error
);
   // ==========================================
   // properties
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire logic take = cmd_valid;
   property p_cont_set;
      take && cmd == trig_chan_pkg::cmd_continuous_arm |=> continuous_arm_flag == $past(cmd_arg[0]);
   endproperty
   a_cont_set: assert property (p_cont_set) else $error("continuous flag not taken from arg");
   property p_cont_clr;
      take && cmd == trig_chan_pkg::cmd_general_reset |=> !continuous_arm_flag;
   endproperty
   a_cont_clr: assert property (p_cont_clr) else $error("general reset kept continuous flag");
   property p_cont_q;
      take && cmd == trig_chan_pkg::cmd_continuous_query
      |=> ans_valid && ans_kind == trig_chan_pkg::ans_flag && ans_data[0] == continuous_arm_flag;
   endproperty
   a_cont_q: assert property (p_cont_q) else $error("continuous query answer wrong");
   property p_cont_armed;
      continuous_arm_flag |-> trigger_armed;
   endproperty
   a_cont_armed: assert property (p_cont_armed) else $error("continuous but not armed");
   property p_fire;
      take && cmd == trig_chan_pkg::cmd_trigger && trigger_armed
      |=> trigger_fire && trigger_armed == continuous_arm_flag;
   endproperty
   a_fire: assert property (p_fire) else $error("armed trigger misbehaved");
   property p_no_fire;
      take && cmd == trig_chan_pkg::cmd_trigger && !trigger_armed |=> !trigger_fire;
   endproperty
   a_no_fire: assert property (p_no_fire) else $error("fired while unarmed");
   property p_sel_q;
      take && cmd == trig_chan_pkg::cmd_selected_query
      |=> ans_valid && ans_kind == trig_chan_pkg::ans_channel && ans_data[4:0] == selected_channel;
   endproperty
   a_sel_q: assert property (p_sel_q) else $error("selected query answer wrong");
   property p_sel_zero;
      take && cmd == trig_chan_pkg::cmd_channel_select && cmd_arg == 5'h00
      |=> cmd_error && $stable(selected_channel);
   endproperty
   a_sel_zero: assert property (p_sel_zero) else $error("channel zero accepted");
   property p_gate;
      output_gated_off && $past(output_gated_off) |-> out_voltage == 16'h0000 && out_current == 16'h0000;
   endproperty
   a_gate: assert property (p_gate) else $error("gated output not zero");
   property p_warn;
      take && cmd_extra && (cmd == trig_chan_pkg::cmd_measured_voltage_query ||
                            cmd == trig_chan_pkg::cmd_measured_current_query)
      |=> questionable[trig_chan_pkg::ques_cmd_warning_bit];
   endproperty
   a_warn: assert property (p_warn) else $error("warning bit not set");
endmodule
bind trigger_arm_channel_select trig_props u_props (.clk, .rst, .cmd_valid, .cmd, .cmd_arg, .cmd_extra,
   .ans_valid, .ans_kind, .ans_data, .selected_channel, .out_voltage, .out_current, .output_gated_off,
   .trigger_armed, .trigger_fire, .continuous_arm_flag, .questionable, .cmd_error);

// >>> tb/supply_bus_model.sv
/*
 supply_bus_model: behavioural set of supplies on the fieldbus.
 assumes: bench sets which supplies are powered and which report power loss.
*/
`timescale 1ns/100ps
module supply_bus_model
(
   input wire logic [31:0] power_on,
   input wire logic [31:0] fault,
   input wire logic [15:0] out_voltage,
   input wire logic [15:0] out_current,
   output logic [31:0] bus_present,
   output logic [31:0] bus_power_loss,
   output logic [15:0] meas_voltage,
   output logic [15:0] meas_current
);
   // ==========================================
   // presence and terminals
   assign bus_present = power_on;
   assign bus_power_loss = fault & power_on;
   assign meas_voltage = out_voltage;
   // load draws half the limit, so measured differs from programmed
   assign meas_current = out_current >> 1;
endmodule

// >>> tb/test_trigger_arm_channel_select.sv
/*
 test_trigger_arm_channel_select: directed bench for arming and channel commands.
 assumes: supply_bus_model on the fieldbus side, 200 MHz clock.
*/
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
   $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module test_trigger_arm_channel_select;
   // ==========================================
   // signals
   logic clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, cmd_extra = 1'b0, ans_valid, output_gated_off;
   logic trigger_armed, trigger_fire, continuous_arm_flag, cmd_error;
   trig_chan_pkg::cmd_t cmd = trig_chan_pkg::cmd_none;
   trig_chan_pkg::ans_t ans_kind;
   logic [4:0] cmd_arg = 5'h00, selected_channel;
   logic [31:0] power_on = 32'h0000001e, fault = 32'h00000000;
   logic [31:0] bus_present, bus_power_loss, ans_data, known_channels, supply_reset;
   logic [15:0] prog_voltage = 16'h1234, prog_current = 16'h0566;
   logic [15:0] meas_voltage, meas_current, out_voltage, out_current, questionable;
   int fails = 0, n_tests = 0;
   always #2.5 clk = ~clk;
   trigger_arm_channel_select dut_u (.clk, .rst, .cmd_valid, .cmd, .cmd_arg, .cmd_extra, .bus_present,
      .bus_power_loss, .prog_voltage, .prog_current, .meas_voltage, .meas_current, .ans_valid, .ans_kind,
      .ans_data, .selected_channel, .known_channels, .supply_reset, .out_voltage, .out_current,
      .output_gated_off, .trigger_armed, .trigger_fire, .continuous_arm_flag, .questionable, .cmd_error);
   supply_bus_model sup_u (.power_on, .fault, .out_voltage, .out_current, .bus_present, .bus_power_loss,
      .meas_voltage, .meas_current);
   // ==========================================
   // tasks
   // returns at the falling edge after the taking edge, where answers stand
   task automatic send(input trig_chan_pkg::cmd_t c, input logic [4:0] a, input logic x);
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd = c;
      cmd_arg = a;
      cmd_extra = x;
      @(negedge clk);
      cmd_valid = 1'b0;
      cmd_extra = 1'b0;
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
      begin
         $display("DONE - PASS");
      end
      else
      begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ==========================================
   // tests
   initial
   begin
      #20000;
      fails++;
      conclude();
   end
   initial
   begin
      idle(16);
      rst = 1'b0;
      `CHK(selected_channel, 5'h01)
      `CHK(known_channels, 32'h00000000)
      $display("test reset done");
      send(trig_chan_pkg::cmd_single_arm, 5'h00, 1'b0);
      `CHK(trigger_armed, 1'b1)
      send(trig_chan_pkg::cmd_trigger, 5'h00, 1'b0);
      `CHK({trigger_fire, trigger_armed}, 2'b10)
      send(trig_chan_pkg::cmd_trigger, 5'h00, 1'b0);
      `CHK(trigger_fire, 1'b0)
      send(trig_chan_pkg::cmd_continuous_arm, 5'h01, 1'b0);
      send(trig_chan_pkg::cmd_continuous_query, 5'h00, 1'b0);
      `CHK({ans_valid, ans_kind, ans_data[0]}, {1'b1, trig_chan_pkg::ans_flag, 1'b1})
      send(trig_chan_pkg::cmd_trigger, 5'h00, 1'b0);
      `CHK({trigger_fire, trigger_armed}, 2'b11)
      send(trig_chan_pkg::cmd_single_arm, 5'h00, 1'b0);
      `CHK(trigger_armed, 1'b1)
      send(trig_chan_pkg::cmd_continuous_arm, 5'h00, 1'b0);
      `CHK({continuous_arm_flag, trigger_armed}, 2'b00)
      send(trig_chan_pkg::cmd_continuous_arm, 5'h01, 1'b0);
      send(trig_chan_pkg::cmd_general_reset, 5'h00, 1'b0);
      `CHK(continuous_arm_flag, 1'b0)
      `CHK(known_channels, 32'h0000001e)
      $display("test arming done");
      send(trig_chan_pkg::cmd_channel_list_query, 5'h00, 1'b0);
      `CHK({ans_kind, ans_data}, {trig_chan_pkg::ans_list, 32'h0000001e})
      send(trig_chan_pkg::cmd_channel_select, 5'h02, 1'b0);
      `CHK({selected_channel, supply_reset}, {5'h02, 32'h00000004})
      idle(24);
      send(trig_chan_pkg::cmd_selected_query, 5'h00, 1'b0);
      `CHK(ans_data[4:0], 5'h02)
      send(trig_chan_pkg::cmd_numbered_select, 5'h03, 1'b0);
      `CHK({selected_channel, supply_reset}, {5'h03, 32'h00000008})
      idle(24);
      send(trig_chan_pkg::cmd_channel_select, 5'h00, 1'b0);
      `CHK({cmd_error, selected_channel}, {1'b1, 5'h03})
      fault = 32'h00000010;
      idle(24);
      `CHK(known_channels[4], 1'b0)
      send(trig_chan_pkg::cmd_channel_select, 5'h04, 1'b0);
      `CHK({cmd_error, selected_channel}, {1'b1, 5'h03})
      fault = 32'h00000000;
      idle(24);
      send(trig_chan_pkg::cmd_channel_list_query, 5'h00, 1'b0);
      `CHK(ans_data, 32'h0000000e)
      send(trig_chan_pkg::cmd_channel_select, 5'h04, 1'b0);
      idle(24);
      `CHK({known_channels, supply_reset}, {32'h0000001e, 32'h00000000})
      fault = 32'h00000010;
      idle(8);
      `CHK({questionable[11], known_channels[4]}, 2'b10)
      fault = 32'h00000000;
      idle(8);
      $display("test channels done");
      `CHK({out_voltage, out_current}, {prog_voltage, prog_current})
      send(trig_chan_pkg::cmd_output_gate, 5'h00, 1'b0);
      idle(2);
      `CHK({output_gated_off, out_voltage, out_current}, {1'b1, 32'h00000000})
      send(trig_chan_pkg::cmd_measured_voltage_query, 5'h00, 1'b0);
      `CHK(ans_data[15:0], 16'h0000)
      send(trig_chan_pkg::cmd_output_gate, 5'h01, 1'b0);
      idle(2);
      `CHK({out_voltage, out_current}, {prog_voltage, prog_current})
      send(trig_chan_pkg::cmd_measured_current_query, 5'h00, 1'b0);
      `CHK({ans_kind, ans_data[15:0]}, {trig_chan_pkg::ans_current, 16'h02b3})
      `CHK(questionable[13], 1'b0)
      send(trig_chan_pkg::cmd_measured_voltage_query, 5'h00, 1'b1);
      `CHK({ans_kind, ans_data[15:0]}, {trig_chan_pkg::ans_voltage, 16'h1234})
      idle(1);
      `CHK(questionable[13], 1'b1)
      $display("test output done");
      conclude();
   end
endmodule
